// >>> hdl/tol_thermal.sv
// Thermal overload protection core with APB register access.
// Assumes phase RMS currents, negative sequence and ambient come in
// synchronous to pclk, with one meas_strobe pulse per measurement period.
`timescale 1ns/1ps
`default_nettype none
`include "tol_regs.svh"
module tol_thermal (
	// APB slave
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Measurements
	input wire tol_pkg::tol_cur_t phase_rms_1,
	input wire tol_pkg::tol_cur_t phase_rms_2,
	input wire tol_pkg::tol_cur_t phase_rms_3,
	input wire tol_pkg::tol_cur_t neg_seq_current,
	input wire logic meas_strobe,
	input wire logic [7:0] ambient_temp,
	input wire logic ambient_valid,
	// Orders
	input wire logic thermal_inhibit_input,
	input wire logic remote_inhibit_order,
	input wire logic remote_enable_order,
	input wire logic starts_inhibit,
	// Indications
	output logic alarm,
	output logic trip_order,
	output logic restart_block_indication,
	output logic hot_state
);
	import tol_pkg::*;

	// Saturate a wide result to sixteen bits
	function automatic logic [15:0] sat16(input logic [23:0] v, input logic ovf);
		return (ovf || v[23:16] != 8'h00) ? 16'hFFFF : v[15:0];
	endfunction

	// Reset value of one parameter group word
	function automatic logic [31:0] par_rst(input int idx);
		logic [31:0] r;
		r = `TOL_RST_TC;
		if (4'(idx % 5) == `TOL_P_ALARM) begin
			r = `TOL_RST_ALARM;
		end else if (4'(idx % 5) == `TOL_P_TRIP) begin
			r = `TOL_RST_TRIP;
		end else if (4'(idx % 5) == `TOL_P_INIT) begin
			r = `TOL_RST_INIT;
		end
		return r;
	endfunction

	tol_cur_if cur_if ();
	tol_weight u_weight (
		.cur(cur_if)
	);

	tol_state_e state_q;
	logic [31:0] par_q [0:`TOL_P_COUNT-1];
	logic [1:0] ksel_q;
	logic [15:0] base_q, lock_q, start_heat_q, saved_q, eff_q, wgt_q;
	logic [7:0] tmax_q, amb_q;
	logic amb_ok_q, running_q, grp_b_q, inhib_q, up_q;
	logic [23:0] heat_q, quo_q;
	tol_cur_t imax_q, ineg_q;
	logic [55:0] dvd_q;
	logic [31:0] dvs_q;
	logic [32:0] rem_q;
	logic qsat_q;
	logic [5:0] cnt_q;

	// Bus decode; zero wait states, so pready is a constant high
	wire wr_en = psel & penable & pwrite;
	wire rd_setup = psel & ~penable & ~pwrite;
	wire aligned = paddr[1:0] == 2'b00;
	wire grp_hit = aligned && paddr >= `TOL_ADDR_GRP0 && paddr <= `TOL_ADDR_GRPL;
	wire [7:0] grp_off = paddr - `TOL_ADDR_GRP0;
	wire [3:0] grp_idx = grp_off[5:2];
	wire hit_ctrl = paddr == `TOL_ADDR_CTRL;
	wire hit_status = paddr == `TOL_ADDR_STATUS;
	wire hit_base = paddr == `TOL_ADDR_BASE;
	wire hit_lock = paddr == `TOL_ADDR_LOCK;
	wire hit_tmax = paddr == `TOL_ADDR_TMAX;
	wire hit_start = paddr == `TOL_ADDR_START;
	wire hit_heat = paddr == `TOL_ADDR_HEAT;
	wire hit_saved = paddr == `TOL_ADDR_SAVED;
	wire hit_weight = paddr == `TOL_ADDR_WEIGHT;
	wire mapped = grp_hit | hit_ctrl | hit_status | hit_base | hit_lock | hit_tmax
		| hit_start | hit_heat | hit_saved | hit_weight;
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~mapped;
	wire wr_saved = wr_en & hit_saved;

	// Active parameter group follows the locked-rotor decision
	wire [3:0] gbase = grp_b_q ? `TOL_GRP_B : 4'h0;
	wire [15:0] act_alarm = par_q[gbase + `TOL_P_ALARM][15:0];
	wire [15:0] act_trip = par_q[gbase + `TOL_P_TRIP][15:0];
	wire [15:0] act_init = par_q[gbase + `TOL_P_INIT][15:0];
	wire [3:0] tc_idx = gbase + (running_q ? `TOL_P_HEAT_TC : `TOL_P_COOL_TC);
	wire [23:0] act_tc = par_q[tc_idx][23:0];

	// Largest phase current; inputs already RMS with harmonics to the 17th
	wire [15:0] imax_w = (phase_rms_1 >= phase_rms_2)
		? ((phase_rms_1 >= phase_rms_3) ? phase_rms_1 : phase_rms_3)
		: ((phase_rms_2 >= phase_rms_3) ? phase_rms_2 : phase_rms_3);
	wire [19:0] imax_x10 = 20'(imax_w) * `TOL_RUN_MUL;
	wire run_now = imax_x10 > 20'(base_q);
	wire stop_now = imax_x10 < 20'(base_q);
	wire capture = state_q == ST_IDLE && meas_strobe;
	wire start_evt = capture && run_now && !running_q;

	// Serial restoring divider, one quotient bit per clock
	wire [32:0] rem_sh = {rem_q[31:0], dvd_q[55]};
	wire rem_ge = rem_sh >= {1'b0, dvs_q};
	wire [32:0] rem_nx = rem_ge ? rem_sh - {1'b0, dvs_q} : rem_sh;
	wire [23:0] quo_nx = {quo_q[22:0], rem_ge};
	wire div_last = cnt_q == 6'h01;
	wire [15:0] div_res = sat16(quo_nx, qsat_q | quo_q[23]);

	// Heat-rise target from the squared weighted current over base squared
	wire q_done = state_q == ST_DIV_Q && div_last;
	wire t_done = state_q == ST_DIV_T && div_last;
	wire a_done = state_q == ST_DIV_A && div_last;
	wire [23:0] target = {div_res, `TOL_E_PAD};
	wire tgt_up = target > heat_q;
	wire [23:0] diff_w = tgt_up ? target - heat_q : heat_q - target;
	wire [23:0] heat_step = up_q ? heat_q + quo_nx : heat_q - quo_nx;

	// Ambient correction, only above the reference temperature
	wire amb_hot = amb_ok_q && amb_q > `TOL_AMB_REF;
	wire amb_sat = amb_hot && amb_q >= tmax_q;
	wire [7:0] amb_num = tmax_q - `TOL_AMB_REF;
	wire [7:0] amb_den = tmax_q - amb_q;
	wire [23:0] amb_prod = 24'(heat_step[23:8]) * 24'(amb_num);

	// Divider load selection for the three divisions of one period
	wire ld_q = state_q == ST_LOAD;
	wire ld_a = t_done && amb_hot && !amb_sat;
	wire div_ld = ld_q | q_done | ld_a;
	wire [55:0] ld_dvd = ld_q ? {4'h0, cur_if.ieq_sq, `TOL_Q_PAD}
		: q_done ? {32'h0, diff_w} : {32'h0, amb_prod};
	wire [31:0] ld_dvs = ld_q ? 32'(base_q) * 32'(base_q)
		: q_done ? {8'h00, act_tc} : {24'h0, amb_den};

	// Outcome comparisons on the corrected heat rise
	wire trip_d = eff_q > act_trip && !inhib_q && !thermal_inhibit_input;
	wire [16:0] need = {1'b0, eff_q} + {1'b0, start_heat_q};
	wire therm_block = need > {1'b0, act_trip};
	wire [31:0] tenth = 32'(eff_q) * `TOL_TENTH;
	wire [16:0] boost = {1'b0, eff_q} + {1'b0, tenth[31:16]};
	wire [15:0] saved_val = sat16({7'h00, boost}, 1'b0);

	// Measurement sequence: capture, target divide, step divide, ambient divide
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= ST_IDLE;
		end else begin
			unique case (state_q)
				ST_IDLE: state_q <= meas_strobe ? ST_LOAD : ST_IDLE;
				ST_LOAD: state_q <= ST_DIV_Q;
				ST_DIV_Q: state_q <= div_last ? ST_DIV_T : ST_DIV_Q;
				ST_DIV_T: state_q <= div_last ? (ld_a ? ST_DIV_A : ST_IDLE) : ST_DIV_T;
				ST_DIV_A: state_q <= div_last ? ST_IDLE : ST_DIV_A;
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	// Divider datapath
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dvd_q <= '0;
			dvs_q <= '0;
			rem_q <= '0;
			quo_q <= '0;
			qsat_q <= 1'b0;
			cnt_q <= '0;
		end else if (div_ld) begin
			dvd_q <= ld_dvd;
			dvs_q <= ld_dvs;
			rem_q <= '0;
			quo_q <= '0;
			qsat_q <= 1'b0;
			cnt_q <= `TOL_DIV_STEPS;
		end else if (cnt_q != 6'h00) begin
			dvd_q <= {dvd_q[54:0], 1'b0};
			rem_q <= rem_nx;
			quo_q <= quo_nx;
			qsat_q <= qsat_q | quo_q[23];
			cnt_q <= cnt_q - 6'h01;
		end
	end

	// Inputs of one period, run state and group choice taken together
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			imax_q <= '0;
			ineg_q <= '0;
			amb_q <= '0;
			amb_ok_q <= 1'b0;
			running_q <= 1'b0;
			grp_b_q <= 1'b0;
			up_q <= 1'b0;
			wgt_q <= '0;
		end else begin
			if (capture) begin
				imax_q <= imax_w;
				ineg_q <= neg_seq_current;
				amb_q <= ambient_temp;
				amb_ok_q <= ambient_valid;
				running_q <= run_now ? 1'b1 : (stop_now ? 1'b0 : running_q);
				grp_b_q <= imax_w > lock_q;
			end
			if (ld_q) begin
				wgt_q <= cur_if.weighted;
			end
			if (q_done) begin
				up_q <= tgt_up;
			end
		end
	end

	assign cur_if.i_max = imax_q;
	assign cur_if.i_neg = ineg_q;
	assign cur_if.k_sel = tol_ksel_e'(ksel_q);

	// Heat-rise state; group switches never touch it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			heat_q <= '0;
			eff_q <= '0;
		end else if (wr_saved) begin
			heat_q <= {pwdata[15:0], `TOL_E_PAD};
			eff_q <= pwdata[15:0];
		end else if (start_evt && heat_q < {act_init, `TOL_E_PAD}) begin
			heat_q <= {act_init, `TOL_E_PAD};
		end else if (t_done) begin
			heat_q <= heat_step;
			eff_q <= amb_sat ? 16'hFFFF : (ld_a ? eff_q : heat_step[23:8]);
		end else if (a_done) begin
			eff_q <= div_res;
		end
	end

	// Indications are registered; remote inhibit wins over enable
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			inhib_q <= 1'b0;
			alarm <= 1'b0;
			trip_order <= 1'b0;
			restart_block_indication <= 1'b0;
			hot_state <= 1'b0;
		end else begin
			inhib_q <= remote_inhibit_order | (inhib_q & ~remote_enable_order);
			alarm <= eff_q > act_alarm;
			trip_order <= trip_d;
			restart_block_indication <= therm_block | starts_inhibit;
			hot_state <= eff_q > `TOL_HOT_LEVEL;
		end
	end

	// Saved heat rise; a new trip wins over the restart-done clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			saved_q <= '0;
		end else if (trip_d && !trip_order) begin
			saved_q <= saved_val;
		end else if (wr_saved) begin
			saved_q <= pwdata[15:0];
		end else if (!therm_block) begin
			saved_q <= '0;
		end
	end

	// Software-written configuration
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < `TOL_P_COUNT; i++) begin
				par_q[i] <= par_rst(i);
			end
			ksel_q <= 2'h0;
			base_q <= `TOL_RST_BASE;
			lock_q <= `TOL_RST_LOCK;
			tmax_q <= `TOL_RST_TMAX;
			start_heat_q <= `TOL_RST_START;
		end else if (wr_en) begin
			if (grp_hit) begin
				par_q[grp_idx] <= pwdata;
			end
			if (hit_ctrl) begin
				ksel_q <= pwdata[`TOL_CTRL_K_HI:`TOL_CTRL_K_LO];
			end
			if (hit_base) begin
				base_q <= pwdata[15:0];
			end
			if (hit_lock) begin
				lock_q <= pwdata[15:0];
			end
			if (hit_tmax) begin
				tmax_q <= pwdata[7:0];
			end
			if (hit_start) begin
				start_heat_q <= pwdata[15:0];
			end
		end
	end

	// Status word and read selection
	wire [31:0] status_w;
	assign status_w[`TOL_ST_ALARM] = alarm;
	assign status_w[`TOL_ST_TRIP] = trip_order;
	assign status_w[`TOL_ST_RESTART] = restart_block_indication;
	assign status_w[`TOL_ST_HOT] = hot_state;
	assign status_w[`TOL_ST_RUN] = running_q;
	assign status_w[`TOL_ST_GRP_B] = grp_b_q;
	assign status_w[`TOL_ST_INHIBIT] = inhib_q;
	assign status_w[`TOL_ST_BUSY] = state_q != ST_IDLE;
	assign status_w[31:`TOL_ST_W] = '0;
	wire [31:0] rd_mux = grp_hit ? par_q[grp_idx]
		: hit_ctrl ? {29'h0, ksel_q, 1'b0}
		: hit_status ? status_w
		: hit_base ? {16'h0, base_q}
		: hit_lock ? {16'h0, lock_q}
		: hit_tmax ? {24'h0, tmax_q}
		: hit_start ? {16'h0, start_heat_q}
		: hit_heat ? {16'h0, eff_q}
		: hit_saved ? {16'h0, saved_q}
		: hit_weight ? {16'h0, wgt_q} : 32'h0;

	// Read data captured in the setup phase so it stands through the access
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= '0;
		end else if (rd_setup) begin
			prdata <= rd_mux;
		end
	end
endmodule
`default_nettype wire

// >>> inc/tol_regs.svh
// Register map, field positions, reset values and fixed thresholds of the
// thermal overload block. Definitions only; included by the package users.
`ifndef TOL_REGS_SVH
`define TOL_REGS_SVH

// Byte offsets on the APB window
`define TOL_ADDR_CTRL 8'h00
`define TOL_ADDR_STATUS 8'h04
`define TOL_ADDR_BASE 8'h08
`define TOL_ADDR_LOCK 8'h0C
`define TOL_ADDR_GRP0 8'h10
`define TOL_ADDR_GRPL 8'h34
`define TOL_ADDR_TMAX 8'h38
`define TOL_ADDR_START 8'h3C
`define TOL_ADDR_HEAT 8'h40
`define TOL_ADDR_SAVED 8'h44
`define TOL_ADDR_WEIGHT 8'h48

// Parameter group layout: five words per group, group B after group A
`define TOL_P_ALARM 4'h0
`define TOL_P_TRIP 4'h1
`define TOL_P_INIT 4'h2
`define TOL_P_HEAT_TC 4'h3
`define TOL_P_COOL_TC 4'h4
`define TOL_GRP_B 4'h5
`define TOL_P_COUNT 10

// CTRL and STATUS fields
`define TOL_CTRL_K_LO 1
`define TOL_CTRL_K_HI 2
`define TOL_ST_ALARM 0
`define TOL_ST_TRIP 1
`define TOL_ST_RESTART 2
`define TOL_ST_HOT 3
`define TOL_ST_RUN 4
`define TOL_ST_GRP_B 5
`define TOL_ST_INHIBIT 6
`define TOL_ST_BUSY 7
`define TOL_ST_W 8

// Reset values (heat rise in Q4.12, 16'h1000 is 100 %)
`define TOL_RST_ALARM 32'h0000_1000
`define TOL_RST_TRIP 32'h0000_1333
`define TOL_RST_INIT 32'h0000_0000
`define TOL_RST_TC 32'h0000_0100
`define TOL_RST_BASE 16'h0100
`define TOL_RST_LOCK 16'hFFFF
`define TOL_RST_TMAX 8'h78
`define TOL_RST_START 16'h0400

// Fixed figures of the thermal model
`define TOL_AMB_REF 8'h28
`define TOL_RUN_MUL 20'h0000A
`define TOL_HOT_LEVEL 16'h0800
`define TOL_TENTH 32'h0000_199A
`define TOL_Q_PAD 12'h000
`define TOL_E_PAD 8'h00
`define TOL_DIV_STEPS 6'h38
`define TOL_K_0 6'h00
`define TOL_K_225 6'h09
`define TOL_K_45 6'h12
`define TOL_K_9 6'h24

`endif

// >>> inc/tol_pkg.sv
// Types shared by the thermal overload block and its current calculator.
// Assumes nothing beyond a SystemVerilog compiler.
package tol_pkg;
	typedef enum logic [2:0] {ST_IDLE, ST_LOAD, ST_DIV_Q, ST_DIV_T, ST_DIV_A} tol_state_e;
	typedef enum logic [1:0] {K_ZERO, K_TWO_QTR, K_FOUR_HALF, K_NINE} tol_ksel_e;
	typedef logic [15:0] tol_cur_t;
endpackage

// >>> inc/tol_cur_if.sv
// Carrier between the thermal block and its weighted-current calculator.
// Assumes tol_pkg is compiled first.
`timescale 1ns/1ps
`default_nettype none
interface tol_cur_if;
	tol_pkg::tol_cur_t i_max;
	tol_pkg::tol_cur_t i_neg;
	tol_pkg::tol_ksel_e k_sel;
	logic [39:0] ieq_sq;
	tol_pkg::tol_cur_t weighted;
	modport calc (input i_max, input i_neg, input k_sel, output ieq_sq, output weighted);
	modport user (output i_max, output i_neg, output k_sel, input ieq_sq, input weighted);
endinterface
`default_nettype wire

// >>> hdl/tol_weight.sv
// Weighted current from the largest phase current and the negative sequence.
// Assumes registered inputs on the carrier; purely combinational.
`timescale 1ns/1ps
`default_nettype none
`include "tol_regs.svh"
module tol_weight (
	// Currents in, weighted current out
	tol_cur_if.calc cur
);
	import tol_pkg::*;

	// Negative-sequence factor in quarters, only four settings exist
	function automatic logic [5:0] k_quarters(input tol_ksel_e k);
		logic [5:0] r;
		r = `TOL_K_0;
		unique case (k)
			K_ZERO: r = `TOL_K_0;
			K_TWO_QTR: r = `TOL_K_225;
			K_FOUR_HALF: r = `TOL_K_45;
			K_NINE: r = `TOL_K_9;
		endcase
		return r;
	endfunction

	// Bitwise integer square root, saturated to the current width
	function automatic tol_cur_t isqrt(input logic [39:0] v);
		logic [19:0] root;
		logic [19:0] cand;
		root = 20'h00000;
		for (int i = 19; i >= 0; i--) begin
			cand = root | (20'h00001 << i);
			if (40'(cand) * 40'(cand) <= v) begin
				root = cand;
			end
		end
		return (root[19:16] != 4'h0) ? 16'hFFFF : root[15:0];
	endfunction

	wire [31:0] ph_sq = 32'(cur.i_max) * 32'(cur.i_max);
	wire [31:0] ng_sq = 32'(cur.i_neg) * 32'(cur.i_neg);
	wire [39:0] ng_k = 40'(ng_sq) * 40'(k_quarters(cur.k_sel));

	// Squared weighted current; root only for software to read
	assign cur.ieq_sq = 40'(ph_sq) + (ng_k >> 2);
	assign cur.weighted = isqrt(cur.ieq_sq);
endmodule
`default_nettype wire

// >>> tb/tol_thermal_asserts.sv
// Port-level checks of the thermal overload block, bound into it.
// Assumes pclk and presetn as on the block and one clock domain.
`timescale 1ns/1ps
`default_nettype none
module tol_thermal_asserts (
	// Clock, reset and APB
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Orders and indications
	input wire logic thermal_inhibit_input,
	input wire logic remote_inhibit_order,
	input wire logic remote_enable_order,
	input wire logic starts_inhibit,
	input wire logic alarm,
	input wire logic trip_order,
	input wire logic restart_block_indication,
	input wire logic hot_state
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Access phase outside the map or off a word boundary
	wire logic bad_acc;
	assign bad_acc = psel && penable && (paddr > 8'h48 || paddr[1:0] != 2'h0);
	pready_high_a: assert property (pready)
		else $error("pready low");
	slverr_gate_a: assert property (pslverr |-> psel && penable)
		else $error("pslverr outside access");
	unmapped_err_a: assert property (bad_acc |-> pslverr)
		else $error("unmapped access without error");
	unmapped_zero_a: assert property (bad_acc && !pwrite |-> prdata == 32'h0)
		else $error("unmapped read not zero");
	local_inhibit_a: assert property (thermal_inhibit_input |=> !trip_order)
		else $error("trip under inhibit input");
	remote_inhibit_a: assert property (
		remote_inhibit_order ##1 !remote_enable_order [*2] |=> !trip_order)
		else $error("trip after remote inhibit");
	starts_block_a: assert property (starts_inhibit |=> restart_block_indication)
		else $error("starts inhibit not merged");
	trip_blocks_a: assert property (trip_order |-> restart_block_indication)
		else $error("tripped but restart allowed");
	// Status word mirrors the indications seen at its capture edge
	status_mirror_a: assert property (
		psel && !penable && !pwrite && paddr == 8'h04 ##1 penable |->
		prdata[3:0] == {$past(hot_state), $past(restart_block_indication),
		$past(trip_order), $past(alarm)})
		else $error("status bits differ from outputs");
	cover property ($rose(trip_order));
	cover property (remote_inhibit_order ##[1:8] remote_enable_order);
	cover property (bad_acc);
endmodule
bind tol_thermal tol_thermal_asserts tol_thermal_asserts_inst (.pclk, .presetn, .psel,
	.penable, .pwrite, .paddr, .prdata, .pready, .pslverr, .thermal_inhibit_input,
	.remote_inhibit_order, .remote_enable_order, .starts_inhibit, .alarm, .trip_order,
	.restart_block_indication, .hot_state);
`default_nettype wire

// >>> tb/tol_meas_model.sv
// Measurement side: phase RMS values, negative sequence and period strobe.
// Assumes the bench asks for one period at a time with meas_req.
`timescale 1ns/1ps
`default_nettype none
module tol_meas_model (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Bench side
	input wire logic meas_req,
	input wire logic [63:0] cur_set,
	output logic meas_done,
	// Block side
	output var tol_pkg::tol_cur_t phase_rms_1,
	output var tol_pkg::tol_cur_t phase_rms_2,
	output var tol_pkg::tol_cur_t phase_rms_3,
	output var tol_pkg::tol_cur_t neg_seq_current,
	output logic meas_strobe
);
	import tol_pkg::*;
	logic [7:0] wait_q;
	// Spacing of 200 cycles covers the slowest update with ambient
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wait_q <= 8'h00;
			meas_strobe <= 1'b0;
			{phase_rms_1, phase_rms_2, phase_rms_3, neg_seq_current} <= 64'h0;
		end else if (meas_req && wait_q == 8'h00) begin
			wait_q <= 8'hC8;
			meas_strobe <= 1'b1;
			{phase_rms_1, phase_rms_2, phase_rms_3, neg_seq_current} <= cur_set;
		end else begin
			meas_strobe <= 1'b0;
			wait_q <= (wait_q == 8'h00) ? 8'h00 : wait_q - 8'h01;
		end
	end
	assign meas_done = wait_q == 8'h00 && !meas_req;
endmodule
`default_nettype wire

// >>> tb/tol_thermal_bench.sv
// Self-checking bench of the thermal overload block over APB.
// Assumes the checker binds itself; no other files needed.
`timescale 1ns/1ps
`default_nettype none
module tol_thermal_bench;
	import tol_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic [7:0] paddr, ambient_temp;
	logic [31:0] pwdata, prdata, rd, lfsr, l2;
	logic meas_req, meas_done, meas_strobe, ambient_valid, starts_inhibit;
	logic thermal_inhibit_input, remote_inhibit_order, remote_enable_order;
	logic alarm, trip_order, restart_block_indication, hot_state;
	logic [63:0] cur_set, cur;
	logic [15:0] m;
	tol_cur_t phase_rms_1, phase_rms_2, phase_rms_3, neg_seq_current;
	int n_fail, compares, i;
	logic [7:0] ra [11] = '{8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20,
		8'h24, 8'h38, 8'h3C};
	logic [31:0] rv [11] = '{32'h0, 32'h100, 32'hFFFF, 32'h1000, 32'h1333, 32'h0,
		32'h100, 32'h100, 32'h1000, 32'h78, 32'h400};
	logic [15:0] wa [4] = '{16'h64, 16'h40, 16'h30, 16'h40};
	logic [15:0] wb [4] = '{16'h10, 16'h20, 16'h40, 16'h10};
	int kq [4] = '{0, 9, 18, 36};
	tol_thermal tol_thermal_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .phase_rms_1, .phase_rms_2, .phase_rms_3,
		.neg_seq_current, .meas_strobe, .ambient_temp, .ambient_valid,
		.thermal_inhibit_input, .remote_inhibit_order, .remote_enable_order,
		.starts_inhibit, .alarm, .trip_order, .restart_block_indication, .hot_state);
	tol_meas_model tol_meas_model_inst (.pclk, .presetn, .meas_req, .cur_set, .meas_done,
		.phase_rms_1, .phase_rms_2, .phase_rms_3, .neg_seq_current, .meas_strobe);
	function automatic logic [31:0] lfsr_next(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	// Integer root of phase squared plus K in quarters times negative squared
	function automatic logic [31:0] wexp(input int a, input int b, input int k4);
		int v;
		int r;
		v = a * a + k4 * b * b / 4;
		r = 0;
		while ((r + 1) * (r + 1) <= v) r++;
		return 32'(r);
	endfunction
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
		compares++;
		if (s !== e) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask
	// One APB transfer; request held until pready is seen at an edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk("register", e, rd);
	endtask
	task automatic meas(input logic [63:0] c);
		@(posedge pclk);
		cur_set <= c;
		meas_req <= 1'b1;
		@(posedge pclk);
		meas_req <= 1'b0;
		do @(posedge pclk); while (meas_done !== 1'b1);
	endtask
	// One-cycle remote order: enable when en is high, inhibit otherwise
	task automatic pulse(input logic en);
		if (en) begin
			remote_enable_order <= 1'b1;
		end else begin
			remote_inhibit_order <= 1'b1;
		end
		@(posedge pclk);
		remote_enable_order <= 1'b0;
		remote_inhibit_order <= 1'b0;
		repeat (3) @(posedge pclk);
	endtask
	task automatic report_and_stop;
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end
	// Watchdog well beyond the roughly 3600 cycles the sequence needs
	initial begin
		repeat (30000) @(posedge pclk);
		n_fail++;
		report_and_stop;
	end
	initial begin
		{presetn, psel, penable, pwrite, meas_req, ambient_valid, starts_inhibit} = 7'h00;
		{thermal_inhibit_input, remote_inhibit_order, remote_enable_order} = 3'h0;
		{paddr, ambient_temp, pwdata, cur_set} = 112'h0;
		lfsr = 32'h8EF4;
		n_fail = 0;
		compares = 0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		// Defaults, a refused write and an unmapped read
		foreach (ra[j]) rc(ra[j], rv[j]);
		apb(1'b1, 8'h40, 32'h1234);
		rc(8'h40, 32'h0);
		apb(1'b0, 8'h80, 32'h0);
		chk("slverr", 32'h1, {31'h0, err});
		// Every weighting factor on exact roots
		for (i = 0; i < 4; i++) begin
			apb(1'b1, 8'h00, 32'(i) << 1);
			meas({wa[i], 32'h0, wb[i]});
			rc(8'h48, wexp(wa[i], wb[i], kq[i]));
		end
		// Random phases with zero factor: weighted is the largest phase
		apb(1'b1, 8'h00, 32'h0);
		for (i = 0; i < 6; i++) begin
			lfsr = lfsr_next(lfsr);
			l2 = lfsr_next(lfsr);
			lfsr = l2;
			cur = {lfsr_next(l2) & 32'h0FFF0FFF, l2 & 32'h0FFF0FFF};
			m = cur[63:48];
			if (cur[47:32] > m) m = cur[47:32];
			if (cur[31:16] > m) m = cur[31:16];
			meas(cur);
			rc(8'h48, {16'h0, m});
		end
		// Twice base current for one period with unit heating constant
		apb(1'b1, 8'h44, 32'h0);
		apb(1'b1, 8'h1C, 32'h1);
		apb(1'b1, 8'h20, 32'h2);
		meas({16'h0200, 48'h0});
		rc(8'h40, 32'h4000);
		rc(8'h44, 32'h4666);
		chk("flags", 32'hF, {trip_order, alarm, hot_state, restart_block_indication});
		thermal_inhibit_input <= 1'b1;
		repeat (3) @(posedge pclk);
		chk("trip", 32'h0, {31'h0, trip_order});
		thermal_inhibit_input <= 1'b0;
		pulse(1'b0);
		chk("trip", 32'h0, {31'h0, trip_order});
		pulse(1'b1);
		chk("trip", 32'h1, {31'h0, trip_order});
		// Cooling, first with hot ambient doubling the reported heat
		ambient_temp <= 8'h50;
		ambient_valid <= 1'b1;
		meas(64'h0);
		rc(8'h40, 32'h4000);
		ambient_valid <= 1'b0;
		meas(64'h0);
		rc(8'h40, 32'h1000);
		chk("restart", 32'h1, {31'h0, restart_block_indication});
		meas(64'h0);
		rc(8'h44, 32'h0);
		chk("flags", 32'h0, {29'h0, restart_block_indication, hot_state, trip_order});
		// Starts-per-hour inhibit alone must raise the restart block
		starts_inhibit <= 1'b1;
		repeat (2) @(posedge pclk);
		chk("restart", 32'h1, {31'h0, restart_block_indication});
		starts_inhibit <= 1'b0;
		// Running threshold at a tenth of base, then the locked-rotor group
		meas({16'h001A, 48'h0});
		rc(8'h04, 32'h10);
		meas({16'h0019, 48'h0});
		rc(8'h04, 32'h0);
		apb(1'b1, 8'h0C, 32'h100);
		// Initial heat of group A lifts the model on the stopped-to-running start
		apb(1'b1, 8'h18, 32'h800);
		meas({16'h0101, 48'h0});
		apb(1'b0, 8'h04, 32'h0);
		chk("group", 32'h1, {31'h0, rd[5]});
		rc(8'h40, 32'h808);
		// Restored heat after supply loss
		apb(1'b1, 8'h0C, 32'hFFFF);
		apb(1'b1, 8'h44, 32'h1800);
		rc(8'h40, 32'h1800);
		chk("alarm", 32'h1, {31'h0, alarm});
		rc(8'h44, 32'h1A66);
		report_and_stop;
	end
endmodule
`default_nettype wire
